// >>> include/hub_port_pkg.sv
// Package with register map, field positions and timing for the hub port power block
package hub_port_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS  = 2;
  localparam int ADDR_WIDTH = 12;
  localparam int SYNC_WIDTH = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [11:0] OC_FLAG_ADDR = 12'h008;
  localparam logic [11:0] STRAP_ADDR   = 12'h00C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_POWER_LSB      = 0;
  localparam int CTRL_SENSE_LSB      = 2;
  localparam int STATUS_DISABLED_LSB = 0;
  localparam int STATUS_POWER_LSB    = 2;
  localparam int STATUS_VBUS_BIT     = 4;
  localparam int STATUS_CONNECT_BIT  = 5;
  localparam int STRAP_DPLUS_LSB     = 0;
  localparam int STRAP_DMINUS_LSB    = 2;
  localparam logic [1:0] POWER_REQ_RESET  = 2'h0;
  localparam logic [1:0] SENSE_MODE_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Synchroniser bit map and reset levels
  // ----------------------------------------------------------------
  localparam int SYNC_DPLUS_LSB  = 0;
  localparam int SYNC_DMINUS_LSB = 2;
  localparam int SYNC_VBUS_BIT   = 4;
  localparam int SYNC_RESET_BIT  = 5;
  localparam int SYNC_PIN_LSB    = 6;
  localparam logic [7:0] SYNC_RESET_VALUE = 8'hE0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ          = 50_000_000;
  localparam int RECONNECT_HOLD_US = 10;
  localparam int RECONNECT_HOLD_CYCLES =
    (RECONNECT_HOLD_US * (CLOCK_HZ / 1_000_000) < 1) ? 1 :
    RECONNECT_HOLD_US * (CLOCK_HZ / 1_000_000);
  localparam logic [9:0] HOLD_LOAD = 10'(RECONNECT_HOLD_CYCLES);
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;
  localparam logic       OC_ACTIVE_LEVEL     = 1'b0;

  // ----------------------------------------------------------------
  // Types and decoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {UP_DETACHED, UP_HOLDOFF, UP_CONNECTED} upstream_state_type;

  function automatic logic port_disabled(input logic dplus, input logic dminus);
    return dplus & dminus;
  endfunction : port_disabled

  function automatic logic addr_known(input logic [11:0] addr);
    return (addr == CTRL_ADDR) || (addr == STATUS_ADDR) ||
           (addr == OC_FLAG_ADDR) || (addr == STRAP_ADDR);
  endfunction : addr_known

endpackage : hub_port_pkg

// >>> hdl/input_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module input_sync3 #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      stable <= RESET_VALUE;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & stable);
    end
  end

endmodule : input_sync3

// >>> hdl/hub_port_power_ctl.sv
// Hub downstream port power, strap capture and upstream power tracking
// Functional notes
// - Latch straps at power-on and reset release
// - Port disable from both straps together
// - Upstream power detect gates upstream connection
// - Power detect toggle forces renegotiation, no reset
// - Output mode: high enables port power
// - Input mode: pin reports overcurrent
`timescale 1ns/1ns
module hub_port_power_ctl
  import hub_port_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_reset_n,
  input  wire logic [1:0]  port_dplus_disable_strap,
  input  wire logic [1:0]  port_dminus_disable_strap,
  input  wire logic        upstream_power_detect,
  input  wire logic        port1_power_ctl_in,
  output logic             port1_power_ctl_out,
  output logic             port1_power_ctl_oe,
  input  wire logic        port2_power_ctl_in,
  output logic             port2_power_ctl_out,
  output logic             port2_power_ctl_oe,
  output logic             upstream_connect,
  output logic [1:0]       port_overcurrent,
  output logic [1:0]       port_disabled_out
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] sync_raw;
  logic [SYNC_WIDTH-1:0] sync_val;
  logic [1:0]            strap_dplus;
  logic [1:0]            strap_dminus;
  logic                  por_pending;
  logic [2:0]            settle_count;
  logic                  ext_prev;
  logic                  strap_capture;
  logic                  ext_in_reset;
  logic                  vbus;
  logic [1:0]            pin_sync;
  logic [1:0]            power_req;
  logic [1:0]            sense_mode;
  logic [1:0]            oc_flag;
  logic [1:0]            oc_event;
  logic [1:0]            disabled;
  logic [1:0]            power_on;
  logic [1:0]            pin_oe;
  logic [1:0]            next_power_on;
  upstream_state_type    up_state;
  upstream_state_type    next_up_state;
  logic [9:0]            hold_count;
  logic                  vbus_prev;
  logic                  wr_access;
  logic [31:0]           read_value;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign sync_raw = {port2_power_ctl_in, port1_power_ctl_in, ext_reset_n,
                     upstream_power_detect, port_dminus_disable_strap,
                     port_dplus_disable_strap};

  input_sync3 #(.WIDTH(SYNC_WIDTH), .RESET_VALUE(SYNC_RESET_VALUE)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (sync_raw),
    .stable  (sync_val)
  );

  assign ext_in_reset = ~sync_val[SYNC_RESET_BIT];
  assign vbus         = sync_val[SYNC_VBUS_BIT];
  assign pin_sync     = sync_val[SYNC_PIN_LSB +: 2];

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Power-on capture waits for the synchroniser to fill with real pin levels
  assign strap_capture = (por_pending && settle_count == STRAP_SETTLE_CYCLES) ||
                         (!ext_prev && sync_val[SYNC_RESET_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_pending  <= 1'b1;
      settle_count <= 3'h0;
      ext_prev     <= 1'b1;
    end else begin
      ext_prev <= sync_val[SYNC_RESET_BIT];
      if (strap_capture) begin
        por_pending <= 1'b0;
      end
      if (por_pending && settle_count != STRAP_SETTLE_CYCLES) begin
        settle_count <= settle_count + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_dplus  <= 2'h0;
      strap_dminus <= 2'h0;
    end else if (strap_capture) begin
      strap_dplus  <= sync_val[SYNC_DPLUS_LSB +: 2];
      strap_dminus <= sync_val[SYNC_DMINUS_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Upstream connection
  // ----------------------------------------------------------------
  always_comb begin
    next_up_state = up_state;
    case (up_state)
      UP_DETACHED: begin
        if (vbus) begin
          next_up_state = UP_HOLDOFF;
        end
      end
      UP_HOLDOFF: begin
        if (!vbus) begin
          next_up_state = UP_DETACHED;
        end else if (hold_count == 10'h001) begin
          next_up_state = UP_CONNECTED;
        end
      end
      UP_CONNECTED: begin
        // Any toggle drops the link; the holdoff then renegotiates it
        if (!vbus || vbus != vbus_prev) begin
          next_up_state = UP_DETACHED;
        end
      end
      default: next_up_state = UP_DETACHED;
    endcase
    if (ext_in_reset) begin
      next_up_state = UP_DETACHED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_state         <= UP_DETACHED;
      hold_count       <= 10'h000;
      vbus_prev        <= 1'b0;
      upstream_connect <= 1'b0;
    end else begin
      up_state         <= next_up_state;
      vbus_prev        <= vbus;
      upstream_connect <= (next_up_state == UP_CONNECTED);
      if (next_up_state == UP_HOLDOFF && up_state != UP_HOLDOFF) begin
        hold_count <= HOLD_LOAD;
      end else if (hold_count != 10'h000) begin
        hold_count <= hold_count - 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-port power and overcurrent
  // ----------------------------------------------------------------
  assign wr_access = psel && penable && pready && pwrite && addr_known(paddr);

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    assign disabled[i] = port_disabled(strap_dplus[i], strap_dminus[i]);
    // Pin is only read as a report while sense_mode selects input mode, one cycle before pin_oe releases it
    assign oc_event[i] = sense_mode[i] && pin_sync[i] == OC_ACTIVE_LEVEL;
    assign next_power_on[i] = power_req[i] && !disabled[i] && !oc_flag[i] &&
                              !oc_event[i] && !ext_in_reset;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        power_on[i] <= 1'b0;
        pin_oe[i]   <= 1'b1;
        oc_flag[i]  <= 1'b0;
      end else begin
        power_on[i] <= next_power_on[i];
        pin_oe[i]   <= !sense_mode[i];
        // A new event wins over a clear in the same cycle
        oc_flag[i]  <= (oc_flag[i] && !(wr_access && paddr == OC_FLAG_ADDR && pwdata[i])) ||
                       oc_event[i];
      end
    end

    property p_disabled_off; disabled[i] |=> !power_on[i]; endproperty
    a_disabled_off : assert property (p_disabled_off) else $error("disabled port on");
    property p_oc_flag; (sense_mode[i] && pin_sync[i] == OC_ACTIVE_LEVEL) |=> oc_flag[i]; endproperty
    a_oc_flag : assert property (p_oc_flag) else $error("overcurrent not flagged");
    property p_sense_release; sense_mode[i] |=> !pin_oe[i]; endproperty
    a_sense_release : assert property (p_sense_release) else $error("pin driven");
    property p_oc_off; oc_flag[i] |=> !power_on[i]; endproperty
    a_oc_off : assert property (p_oc_off) else $error("power kept on overcurrent");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_power_ctl_out <= 1'b0;
      port2_power_ctl_out <= 1'b0;
      port1_power_ctl_oe  <= 1'b1;
      port2_power_ctl_oe  <= 1'b1;
      port_overcurrent    <= 2'h0;
      port_disabled_out   <= 2'h0;
    end else begin
      port1_power_ctl_out <= next_power_on[0];
      port2_power_ctl_out <= next_power_on[1];
      port1_power_ctl_oe  <= !sense_mode[0];
      port2_power_ctl_oe  <= !sense_mode[1];
      port_overcurrent    <= oc_flag | oc_event;
      port_disabled_out   <= disabled;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_req  <= POWER_REQ_RESET;
      sense_mode <= SENSE_MODE_RESET;
    end else if (wr_access && paddr == CTRL_ADDR) begin
      power_req  <= pwdata[CTRL_POWER_LSB +: 2];
      sense_mode <= pwdata[CTRL_SENSE_LSB +: 2];
    end
  end

  always_comb begin
    read_value = 32'h0000_0000;
    case (paddr)
      CTRL_ADDR: begin
        read_value[CTRL_POWER_LSB +: 2] = power_req;
        read_value[CTRL_SENSE_LSB +: 2] = sense_mode;
      end
      STATUS_ADDR: begin
        read_value[STATUS_DISABLED_LSB +: 2] = disabled;
        read_value[STATUS_POWER_LSB +: 2]    = power_on;
        read_value[STATUS_VBUS_BIT]          = vbus;
        read_value[STATUS_CONNECT_BIT]       = upstream_connect;
      end
      OC_FLAG_ADDR: read_value[1:0] = oc_flag;
      STRAP_ADDR: begin
        read_value[STRAP_DPLUS_LSB +: 2]  = strap_dplus;
        read_value[STRAP_DMINUS_LSB +: 2] = strap_dminus;
      end
      default: read_value = 32'h0000_0000;
    endcase
  end

  // Answer is prepared in the setup cycle, so every access phase takes one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !addr_known(paddr);
      prdata  <= pwrite ? 32'h0000_0000 : read_value;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_strap_hold; !strap_capture |=> $stable({strap_dplus, strap_dminus}); endproperty
  a_strap_hold : assert property (p_strap_hold) else $error("strap changed");
  property p_strap_load; strap_capture |=> strap_dplus == $past(sync_val[1:0]); endproperty
  a_strap_load : assert property (p_strap_load) else $error("strap not taken");
  property p_no_vbus; !vbus |=> !upstream_connect; endproperty
  a_no_vbus : assert property (p_no_vbus) else $error("connected without power");
  property p_holdoff; $rose(vbus) |=> !upstream_connect [*8]; endproperty
  a_holdoff : assert property (p_holdoff) else $error("reconnect too early");
  property p_reconnect; (up_state == UP_HOLDOFF && vbus && !ext_in_reset &&
    hold_count == 10'h001) |=> upstream_connect; endproperty
  a_reconnect : assert property (p_reconnect) else $error("no reconnect");
  property p_drive_high; (next_power_on[0] && !sense_mode[0]) |=>
    port1_power_ctl_out && port1_power_ctl_oe; endproperty
  a_drive_high : assert property (p_drive_high) else $error("port 1 not powered");
  c_ext_capture : cover property (!ext_prev && sync_val[SYNC_RESET_BIT]);
  c_renegotiate : cover property ($fell(upstream_connect) ##[1:1000] $rose(upstream_connect));
  c_overcurrent : cover property (power_on[0] && oc_event[0]);
  c_oc_clear : cover property ($fell(oc_flag[1]));

endmodule : hub_port_power_ctl

// >>> verification/port_supply_model.sv
// Behavioural power switch and current monitor on one port control pin
`timescale 1ns/1ns
module port_supply_model
  import hub_port_pkg::*;
(
  input  wire logic ctl_out,
  input  wire logic ctl_oe,
  input  wire logic fault,
  output logic      pin_level,
  output logic      power_applied
);
  // --------------------------------------------------------------
  // Pin level
  // --------------------------------------------------------------
  // Pull-up holds a released pin high; the monitor only pulls it while released
  assign pin_level = ctl_oe ? ctl_out : (fault ? OC_ACTIVE_LEVEL : 1'b1);
  // Switch passes power only on a driven high level
  assign power_applied = ctl_oe & ctl_out;
endmodule : port_supply_model

// >>> verification/hub_port_power_ctl_tb.sv
// Self-checking testbench for the hub port power and strap block
`timescale 1ns/1ns
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module hub_port_power_ctl_tb;
  import hub_port_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_reset_n = 1'b1;
  logic [1:0]  dplus = 2'h1;
  logic [1:0]  dminus = 2'h3;
  logic        detect = 1'b0;
  logic [1:0]  fault = 2'h0;
  wire logic [1:0] pin_in;
  wire logic [1:0] ctl_out;
  wire logic [1:0] ctl_oe;
  wire logic [1:0] pwr;
  logic        upstream_connect;
  logic [1:0]  port_overcurrent;
  logic [1:0]  port_disabled_out;
  logic [31:0] rdata;
  logic        rerr;
  int          errors = 0;
  int          check_count = 0;
  int          n;

  hub_port_power_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_n(ext_reset_n), .port_dplus_disable_strap(dplus),
    .port_dminus_disable_strap(dminus), .upstream_power_detect(detect),
    .port1_power_ctl_in(pin_in[0]), .port1_power_ctl_out(ctl_out[0]),
    .port1_power_ctl_oe(ctl_oe[0]), .port2_power_ctl_in(pin_in[1]),
    .port2_power_ctl_out(ctl_out[1]), .port2_power_ctl_oe(ctl_oe[1]),
    .upstream_connect(upstream_connect), .port_overcurrent(port_overcurrent),
    .port_disabled_out(port_disabled_out));
  port_supply_model m1 (.ctl_out(ctl_out[0]), .ctl_oe(ctl_oe[0]), .fault(fault[0]),
    .pin_level(pin_in[0]), .power_applied(pwr[0]));
  port_supply_model m2 (.ctl_out(ctl_out[1]), .ctl_oe(ctl_oe[1]), .fault(fault[1]),
    .pin_level(pin_in[1]), .power_applied(pwr[1]));

  always #10 pclk = ~pclk;

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Master holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask : apb

  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : settle

  task automatic wait_level(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) begin
      @(posedge pclk);
      #1;
    end
    if (s !== v) begin
      errors++;
      finish_test();
    end
  endtask : wait_level

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_straps();
    settle(10);
    `CHECK(port_disabled_out, 2'h1)
    `CHECK({ctl_oe, ctl_out}, 4'hC)
    apb(1'b0, STRAP_ADDR, 32'h0);
    `CHECK(rdata, 32'h0000000D)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHECK(rdata, 32'h00000001)
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    apb(1'b0, 12'h010, 32'h0);
    `CHECK({rerr, rdata}, 33'h100000000)
    // Straps moving while running must not be taken
    @(posedge pclk);
    dplus <= 2'h0;
    settle(10);
    `CHECK(port_disabled_out, 2'h1)
  endtask : t_straps

  task automatic t_power();
    apb(1'b1, CTRL_ADDR, 32'h3);
    settle(2);
    `CHECK({ctl_oe, ctl_out, pwr}, 6'h3A)
    apb(1'b1, CTRL_ADDR, 32'h1);
    settle(2);
    `CHECK(pwr, 2'h0)
    apb(1'b1, CTRL_ADDR, 32'h3);
    settle(2);
  endtask : t_power

  task automatic t_upstream();
    @(posedge pclk);
    detect <= 1'b1;
    wait_level(upstream_connect, 1'b1, 600);
    `CHECK(n >= 500 && n <= 512, 1'b1)
    @(posedge pclk);
    detect <= 1'b0;
    wait_level(upstream_connect, 1'b0, 10);
    `CHECK(upstream_connect, 1'b0)
    @(posedge pclk);
    detect <= 1'b1;
    wait_level(upstream_connect, 1'b1, 600);
    `CHECK(n >= 500 && n <= 512, 1'b1)
    #1;
    `CHECK(pwr, 2'h2)
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHECK(rdata, 32'h00000003)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHECK(rdata, 32'h00000039)
  endtask : t_upstream

  task automatic t_overcurrent();
    apb(1'b1, CTRL_ADDR, 32'hB);
    settle(3);
    `CHECK(ctl_oe[1], 1'b0)
    @(posedge pclk);
    fault <= 2'h2;
    for (n = 0; n < 12 && port_overcurrent[1] !== 1'b1; n++) begin
      @(posedge pclk);
      #1;
    end
    `CHECK(port_overcurrent[1], 1'b1)
    @(posedge pclk);
    fault <= 2'h0;
    settle(10);
    `CHECK(port_overcurrent, 2'h2)
    apb(1'b0, OC_FLAG_ADDR, 32'h0);
    `CHECK(rdata, 32'h00000002)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHECK(rdata & 32'h0000000C, 32'h00000000)
    // Power may not return until the sticky flag is cleared
    apb(1'b1, CTRL_ADDR, 32'h3);
    settle(3);
    `CHECK(pwr, 2'h0)
    apb(1'b1, OC_FLAG_ADDR, 32'h2);
    settle(3);
    `CHECK({port_overcurrent, pwr}, 4'h2)
  endtask : t_overcurrent

  task automatic t_ext_reset();
    @(posedge pclk);
    ext_reset_n <= 1'b0;
    settle(8);
    `CHECK(port_disabled_out, 2'h1)
    `CHECK({upstream_connect, pwr}, 3'h0)
    @(posedge pclk);
    ext_reset_n <= 1'b1;
    settle(12);
    `CHECK(port_disabled_out, 2'h0)
    `CHECK(pwr, 2'h3)
    apb(1'b0, STRAP_ADDR, 32'h0);
    `CHECK(rdata, 32'h0000000C)
  endtask : t_ext_reset

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_straps();
    t_power();
    t_upstream();
    t_overcurrent();
    t_ext_reset();
    finish_test();
  end
endmodule : hub_port_power_ctl_tb
